//--- logic/fdcrp_regs.vh
// fdcrp_regs.vh: offsets, field positions, reset values and timing counts
// for the floppy rate and precompensation register block.
// assumes inclusion by bare name from a file under logic/.
`ifndef FDCRP_REGS_VH
`define FDCRP_REGS_VH

// register offsets on the 10-bit i/o address
`define FDCRP_ADDR_W          10
`define FDCRP_TAPE_OFS        10'h3f3
`define FDCRP_RATE_OFS        10'h3f4

// rate select register fields
`define FDCRP_RATE_LSB        0
`define FDCRP_PRECOMP_LSB     2
`define FDCRP_ZERO_BIT        5
`define FDCRP_LOWPWR_BIT      6
`define FDCRP_SWRST_BIT       7
`define FDCRP_RATE_RST        8'h02

// tape register: bits implemented in normal and enhanced mode
`define FDCRP_TAPE_OE_NORMAL  8'h03
`define FDCRP_TAPE_OE_ENH     8'hff

// encoded rate codes and active rate values
`define FDCRP_CODE_500        2'h0
`define FDCRP_CODE_300        2'h1
`define FDCRP_CODE_250        2'h2
`define FDCRP_CODE_1M         2'h3
`define FDCRP_SPD_250         3'h0
`define FDCRP_SPD_300         3'h1
`define FDCRP_SPD_500         3'h2
`define FDCRP_SPD_1M          3'h3
`define FDCRP_SPD_2M          3'h4

// drive rate types
`define FDCRP_DRT_3MODE       2'h1
`define FDCRP_DRT_2MEG        2'h2

// precompensation codes, delays in half steps of 20.83 ns
`define FDCRP_PC_DEFAULT      3'h0
`define FDCRP_PC_ZERO         3'h7
`define FDCRP_HSTEP_2M_DEF    4'h1
`define FDCRP_HSTEP_1M_DEF    4'h2
`define FDCRP_HSTEP_LO_DEF    4'h6
`define FDCRP_START_TRK_RST   8'h00

// software reset pulse length
`define FDCRP_CLK_MHZ         200
`define FDCRP_SWRST_NS        100
`define FDCRP_SWRST_CYC       ((`FDCRP_SWRST_NS * `FDCRP_CLK_MHZ + 999) / 1000)

`endif

//--- logic/fdcrp_top.v
// fdcrp_top.v: tape/drive information register, write-only rate select
// register, write precompensation and density pin mapping of a floppy controller.
// assumes a single-cycle strobe register port on clk_in and that all
// configuration and control inputs come from logic on the same clock.
//
// Function
// R1: normal mode tape register drives bits 1:0 only
// R2: enhanced bits 7:6 are inverted f1 bits 5:4
// R3: disk-kind bits survive hardware and software reset
// R4: enhanced bits 5:4 pick f2 pair by drive
// R5: enhanced bits 3:2 return f1 bits 7:6
// R6: tape bits 1:0 readable and writable always
// R7: active rate follows latest rate or config write
// R8: rate register write only, hard reset 02h
// R9: rate code maps to mfm rate, density
// R10: drive rate type remaps code 01
// R11: precomp code sets write delay steps
// R12: default delay depends on active rate
// R13: precomp starts at configured track, default 0
// R14: software writes zero to rate bit 5
// R15: rate bit 6 enters manual low power
// R16: low power ends on reset or access
// R17: rate bit 7 resets, self clearing
// R18: density pins mapped by drive type
// R19: drive select taken from output control bits
//
// Local design decision: strobed register access.

`timescale 1ns/1ps
`default_nettype none
`include "fdcrp_regs.vh"

module fdcrp_top (
    input  wire                      clk_in,          // controller clock
    input  wire                      resetn_in,       // hardware reset, low
    input  wire [`FDCRP_ADDR_W-1:0]  addr_in,         // register address
    input  wire [7:0]                wr_data_in,      // write data
    input  wire                      wr_strobe_in,    // one-cycle write
    input  wire                      rd_strobe_in,    // one-cycle read
    input  wire                      enhanced_mode_in, // enhanced mode 2 level
    input  wire [7:0]                fdc_config_f1_in, // config register f1
    input  wire [7:0]                fdc_config_f2_in, // config register f2
    input  wire [1:0]                output_control_reg_in, // drive select bits
    input  wire                      ctrl_resetn_in,  // output control reset bit, low
    input  wire                      config_control_reg_wr_in, // config control write pulse
    input  wire [1:0]                config_control_reg_rate_in, // config control rate
    input  wire [1:0]                drive_rate_type_in, // drive rate type
    input  wire [1:0]                drive_kind_in,   // drive type for pins
    input  wire                      fifo_status_access_in, // data/status access
    input  wire                      start_track_wr_in, // configure pulse
    input  wire [7:0]                start_track_in,  // configured start track
    input  wire [7:0]                cur_track_in,    // track being written
    output reg  [7:0]                rd_data_out,     // read data
    output reg  [7:0]                rd_data_oe_out,  // per-bit drive enable
    output reg  [1:0]                rate_code_out,   // active rate code
    output reg  [2:0]                data_rate_out,   // decoded mfm rate
    output reg  [3:0]                precomp_hsteps_out, // delay, 20.83 ns units
    output reg                       precomp_en_out,  // precomp on this track
    output reg                       density_level_out, // high density level
    output reg  [1:0]                density_out_pins_out, // density pins
    output reg                       low_power_out,   // clock/separator off
    output reg                       ctrl_reset_out   // controller soft reset
);

    // decoded mfm rate from code and drive rate type
    function [2:0] fdcrp_rate;
        input [1:0] code;
        input [1:0] drt;
        begin
            case (code)
                `FDCRP_CODE_1M:  fdcrp_rate = `FDCRP_SPD_1M;
                `FDCRP_CODE_500: fdcrp_rate = `FDCRP_SPD_500;
                `FDCRP_CODE_250: fdcrp_rate = `FDCRP_SPD_250;
                default: begin
                    // code 01 is the only code the drive type remaps
                    if (drt == `FDCRP_DRT_3MODE) begin
                        fdcrp_rate = `FDCRP_SPD_500;  // [R10]
                    end else if (drt == `FDCRP_DRT_2MEG) begin
                        fdcrp_rate = `FDCRP_SPD_2M;   // [R10]
                    end else begin
                        fdcrp_rate = `FDCRP_SPD_300;  // [R9]
                    end
                end
            endcase
        end
    endfunction

    // density level: high for codes 11 and 00
    function fdcrp_dens;
        input [1:0] code;
        begin
            fdcrp_dens = (code == `FDCRP_CODE_1M) ||
                         (code == `FDCRP_CODE_500);   // [R9]
        end
    endfunction

    // state
    reg  [1:0]  tape_sel_ff;      // tape drive selection
    reg  [2:0]  precomp_code_ff;  // precomp select bits
    reg  [1:0]  rate_ff;          // most recent rate write
    reg         low_power_ff;     // manual low power flag
    reg  [4:0]  swrst_cnt_ff;     // self-clearing reset timer
    reg  [7:0]  start_trk_ff;     // precomp starting track
    reg  [7:0]  rd_data_ff;
    reg  [7:0]  rd_oe_ff;
    reg  [2:0]  rate_dec_ff;
    reg  [3:0]  hsteps_ff;
    reg         pc_en_ff;
    reg         dens_ff;
    reg  [1:0]  pins_ff;
    reg         ctrl_rst_ff;

    // next values
    reg  [7:0]  nxt_rd_data;
    reg  [7:0]  nxt_rd_oe;
    reg  [2:0]  nxt_rate_dec;
    reg  [3:0]  nxt_hsteps;
    reg  [1:0]  nxt_pins;
    reg  [1:0]  drive_pair;       // f2 pair for selected drive
    reg  [1:0]  nxt_rate;

    wire        wr_tape = wr_strobe_in && (addr_in == `FDCRP_TAPE_OFS);
    wire        rd_tape = rd_strobe_in && (addr_in == `FDCRP_TAPE_OFS);
    wire        wr_rate = wr_strobe_in && (addr_in == `FDCRP_RATE_OFS);
    wire        swrst_req = wr_rate && wr_data_in[`FDCRP_SWRST_BIT];
    wire        swrst_busy = (swrst_cnt_ff != 5'h00);
    wire        soft_reset = swrst_busy || !ctrl_resetn_in;
    // full-width copies of the constants, cut on purpose to the field widths below
    localparam [7:0]  rate_rst_val = `FDCRP_RATE_RST;
    localparam [31:0] swrst_cyc = `FDCRP_SWRST_CYC;
    wire [4:0]  swrst_len = swrst_cyc[4:0];  // 100 ns at 200 mhz

    // tape selection: hard reset only, soft reset leaves it
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            tape_sel_ff <= 2'h0;
        end else if (wr_tape) begin
            tape_sel_ff <= wr_data_in[1:0];  // [R6]
        end
    end

    // rate select register, write only; soft reset does not touch it
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            precomp_code_ff <= rate_rst_val[`FDCRP_PRECOMP_LSB+2:`FDCRP_PRECOMP_LSB];  // [R8]
        end else if (wr_rate) begin
            // bit 5 is ignored; software is expected to write it as zero [R14]
            precomp_code_ff <= wr_data_in[`FDCRP_PRECOMP_LSB+2:`FDCRP_PRECOMP_LSB];
        end
    end

    // active rate: the last of a rate register or config control write; in the same cycle the rate register write wins
    always @* begin
        nxt_rate = rate_ff;
        if (wr_rate) begin
            nxt_rate = wr_data_in[`FDCRP_RATE_LSB+1:`FDCRP_RATE_LSB];  // [R7]
        end else if (config_control_reg_wr_in) begin
            nxt_rate = config_control_reg_rate_in;  // [R7]
        end
    end

    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rate_ff <= rate_rst_val[`FDCRP_RATE_LSB+1:`FDCRP_RATE_LSB];  // [R8]
        end else begin
            rate_ff <= nxt_rate;
        end
    end

    // manual low power: a new request wins over a clearing event
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            low_power_ff <= 1'b0;
        end else if (wr_rate && wr_data_in[`FDCRP_LOWPWR_BIT]) begin
            low_power_ff <= 1'b1;  // [R15]
        end else if (soft_reset || fifo_status_access_in) begin
            low_power_ff <= 1'b0;  // [R16]
        end
    end

    // self-clearing reset bit stretched to the minimum reset width;
    // a second request during the pulse restarts it
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            swrst_cnt_ff <= 5'h00;
        end else if (swrst_req) begin
            swrst_cnt_ff <= swrst_len;  // [R17]
        end else if (swrst_busy) begin
            swrst_cnt_ff <= swrst_cnt_ff - 5'h01;  // [R17]
        end
    end

    // precomp starting track, set by the configure command
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            start_trk_ff <= `FDCRP_START_TRK_RST;  // [R13]
        end else if (start_track_wr_in) begin
            start_trk_ff <= start_track_in;  // [R13]
        end
    end

    // tape/drive information read mux
    always @* begin
        // drive select comes from output control bits 1:0
        case (output_control_reg_in)  // [R19]
            2'h0:    drive_pair = fdc_config_f2_in[1:0];  // [R4]
            2'h1:    drive_pair = fdc_config_f2_in[3:2];  // [R4]
            2'h2:    drive_pair = fdc_config_f2_in[5:4];  // [R4]
            default: drive_pair = fdc_config_f2_in[7:6];  // [R4]
        endcase
        nxt_rd_data = 8'h00;
        nxt_rd_oe = 8'h00;
        if (rd_tape) begin
            if (enhanced_mode_in) begin
                // disk-kind bits are pure decode of f1, so no reset alters them
                nxt_rd_data = {~fdc_config_f1_in[5],   // [R2] [R3]
                               ~fdc_config_f1_in[4],   // [R2] [R3]
                               drive_pair,
                               fdc_config_f1_in[7:6],  // [R5]
                               tape_sel_ff};           // [R6]
                nxt_rd_oe = `FDCRP_TAPE_OE_ENH;
            end else begin
                nxt_rd_data = {6'h00, tape_sel_ff};    // [R6]
                nxt_rd_oe = `FDCRP_TAPE_OE_NORMAL;     // [R1]
            end
        end
    end

    // rate decode, precompensation and density mapping
    always @* begin
        nxt_rate_dec = fdcrp_rate(rate_ff, drive_rate_type_in);  // [R9] [R10]
        case (precomp_code_ff)
            `FDCRP_PC_ZERO: nxt_hsteps = 4'h0;  // [R11]
            `FDCRP_PC_DEFAULT: begin
                if (nxt_rate_dec == `FDCRP_SPD_2M) begin
                    nxt_hsteps = `FDCRP_HSTEP_2M_DEF;  // [R12]
                end else if (nxt_rate_dec == `FDCRP_SPD_1M) begin
                    nxt_hsteps = `FDCRP_HSTEP_1M_DEF;  // [R12]
                end else begin
                    nxt_hsteps = `FDCRP_HSTEP_LO_DEF;  // [R12]
                end
            end
            default: begin
                // 41.67 ns per code step, halved at 2 mbps
                if (nxt_rate_dec == `FDCRP_SPD_2M) begin
                    nxt_hsteps = {1'b0, precomp_code_ff};  // [R11]
                end else begin
                    nxt_hsteps = {precomp_code_ff, 1'b0};  // [R11]
                end
            end
        endcase
        case (drive_kind_in)
            2'h0:    nxt_pins = {rate_ff[0], fdcrp_dens(rate_ff)};   // [R18]
            2'h2:    nxt_pins = {rate_ff[0], rate_ff[1]};            // [R18]
            2'h1:    nxt_pins = {rate_ff[0], ~fdcrp_dens(rate_ff)};  // [R18]
            default: nxt_pins = {rate_ff[1], rate_ff[0]};            // [R18]
        endcase
    end

    // output registers
    always @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rd_data_ff <= 8'h00;
            rd_oe_ff <= 8'h00;
            rate_dec_ff <= `FDCRP_SPD_250;
            hsteps_ff <= `FDCRP_HSTEP_LO_DEF;
            pc_en_ff <= 1'b0;
            dens_ff <= 1'b0;
            pins_ff <= 2'h0;
            ctrl_rst_ff <= 1'b0;
        end else begin
            rd_data_ff <= nxt_rd_data;
            rd_oe_ff <= nxt_rd_oe;
            rate_dec_ff <= nxt_rate_dec;
            hsteps_ff <= nxt_hsteps;
            pc_en_ff <= (cur_track_in >= start_trk_ff);  // [R13]
            dens_ff <= fdcrp_dens(rate_ff);  // [R9]
            pins_ff <= nxt_pins;
            ctrl_rst_ff <= soft_reset;  // [R17]
        end
    end

    // ports straight from flip-flops
    always @* begin
        rd_data_out = rd_data_ff;
        rd_data_oe_out = rd_oe_ff;
        rate_code_out = rate_ff;
        data_rate_out = rate_dec_ff;
        precomp_hsteps_out = hsteps_ff;
        precomp_en_out = pc_en_ff;
        density_level_out = dens_ff;
        density_out_pins_out = pins_ff;
        low_power_out = low_power_ff;
        ctrl_reset_out = ctrl_rst_ff;
    end

endmodule // fdcrp_top

`default_nettype wire

//--- verif/fdcrp_top_asserts.sv
// fdcrp_top_asserts.sv: port-level checker for the rate and precomp register block.
// assumes binding to fdcrp_top: one clock, async active-low hardware reset.
`timescale 1ns/1ps
`default_nettype none
`include "fdcrp_regs.vh"
module fdcrp_top_asserts (
    input wire logic       clk_in,
    input wire logic       resetn_in,
    input wire logic [9:0] addr_in,
    input wire logic [7:0] wr_data_in,
    input wire logic       wr_strobe_in,
    input wire logic       rd_strobe_in,
    input wire logic       enhanced_mode_in,
    input wire logic [7:0] fdc_config_f1_in,
    input wire logic [7:0] fdc_config_f2_in,
    input wire logic [1:0] output_control_reg_in,
    input wire logic       config_control_reg_wr_in,
    input wire logic [1:0] config_control_reg_rate_in,
    input wire logic [1:0] drive_kind_in,
    input wire logic [7:0] rd_data_out,
    input wire logic [7:0] rd_data_oe_out,
    input wire logic [1:0] rate_code_out,
    input wire logic       density_level_out,
    input wire logic [1:0] density_out_pins_out,
    input wire logic       low_power_out,
    input wire logic       ctrl_reset_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    // decoded accesses, shared by several properties
    wire logic rate_wr = wr_strobe_in && addr_in == `FDCRP_RATE_OFS;
    wire logic tape_rd = rd_strobe_in && addr_in == `FDCRP_TAPE_OFS;
    wire logic rd_nrm  = tape_rd && !enhanced_mode_in;
    wire logic rd_enh  = tape_rd && enhanced_mode_in;
    logic [7:0] exp_rd_ff; // enhanced read value predicted from the config levels
    // no reset needed: only consulted one cycle after an enhanced read
    always_ff @(posedge clk_in) begin
        exp_rd_ff <= {~fdc_config_f1_in[5:4], fdc_config_f2_in[{output_control_reg_in, 1'b0} +: 2],
                      fdc_config_f1_in[7:6], 2'b00};
    end
    idle_bus_a: assert property (!$past(rd_strobe_in) |->
        rd_data_oe_out == 8'h00 && rd_data_out == 8'h00)
        else $error("data bus driven outside a read cycle");
    normal_width_a: assert property ($past(rd_nrm) |-> rd_data_oe_out == 8'h03)
        else $error("normal tape read drives wrong bits");
    media_boot_a: assert property ($past(rd_enh) |->
        {rd_data_out[7:6], rd_data_out[3:2]} == {exp_rd_ff[7:6], exp_rd_ff[3:2]})
        else $error("media or boot bits wrong");
    drive_pair_a: assert property ($past(rd_enh) |-> rd_data_out[5:4] == exp_rd_ff[5:4])
        else $error("drive type pair wrong");
    rate_write_a: assert property (rate_wr |=>
        {6'h00, rate_code_out} == ($past(wr_data_in) & 8'h03))
        else $error("rate write not taken");
    cfg_rate_a: assert property (config_control_reg_wr_in && !rate_wr |=>
        rate_code_out == $past(config_control_reg_rate_in))
        else $error("config rate write not taken");
    density_map_a: assert property (density_level_out ==
        ($past(rate_code_out) == 2'h3 || $past(rate_code_out) == 2'h0))
        else $error("density level wrong");
    // pins only follow the inputs once a clock edge has passed out of reset
    pins_kind3_a: assert property ($past(resetn_in) && $past(drive_kind_in) == 2'h3 |->
        density_out_pins_out == $past(rate_code_out))
        else $error("density pins wrong");
    lowpwr_set_a: assert property (rate_wr && wr_data_in[6] |=> low_power_out)
        else $error("low power not entered");
    swrst_len_a: assert property (rate_wr && wr_data_in[7] |->
        ##2 ctrl_reset_out [*8] ##12 ctrl_reset_out)
        else $error("soft reset pulse too short");
    cover property (rd_enh);
    cover property (rate_wr && wr_data_in[7]);
    cover property (config_control_reg_wr_in && rate_wr);
endmodule // fdcrp_top_asserts
bind fdcrp_top fdcrp_top_asserts u_fdcrp_top_asserts (
    .clk_in, .resetn_in, .addr_in, .wr_data_in, .wr_strobe_in, .rd_strobe_in,
    .enhanced_mode_in, .fdc_config_f1_in, .fdc_config_f2_in, .output_control_reg_in,
    .config_control_reg_wr_in, .config_control_reg_rate_in, .drive_kind_in,
    .rd_data_out, .rd_data_oe_out, .rate_code_out, .density_level_out,
    .density_out_pins_out, .low_power_out, .ctrl_reset_out
);
`default_nettype wire

//--- verif/fdcrp_top_tb_top.sv
// fdcrp_top_tb_top.sv: directed bench for the rate and precomp register block.
// assumes fdcrp_top under logic/ with its checker bound alongside.
`timescale 1ns/1ps
`default_nettype none
`include "fdcrp_regs.vh"
module fdcrp_top_tb_top;
    // every input idle at time zero except hardware reset, held low; output control reset released
    logic       clk_in = 1'b0, resetn_in = 1'b0, wr_strobe_in = 1'b0, rd_strobe_in = 1'b0;
    logic       enhanced_mode_in = 1'b0, ctrl_resetn_in = 1'b1, config_control_reg_wr_in = 1'b0;
    logic       fifo_status_access_in = 1'b0, start_track_wr_in = 1'b0;
    logic [9:0] addr_in = 10'h000;
    logic [7:0] wr_data_in = 8'h00, fdc_config_f1_in = 8'h00, fdc_config_f2_in = 8'h00;
    logic [7:0] start_track_in = 8'h00, cur_track_in = 8'h00, rd_data_out, rd_data_oe_out;
    logic [1:0] output_control_reg_in = 2'h0, config_control_reg_rate_in = 2'h0;
    logic [1:0] drive_rate_type_in = 2'h0, drive_kind_in = 2'h0;
    logic [1:0] rate_code_out, density_out_pins_out;
    logic [2:0] data_rate_out;
    logic [3:0] precomp_hsteps_out;
    logic       precomp_en_out, density_level_out, low_power_out, ctrl_reset_out;
    int         fails = 0, checked = 0;
    always #2.5 clk_in = ~clk_in; // 200 MHz
    fdcrp_top u_fdcrp_top (
        .clk_in, .resetn_in, .addr_in, .wr_data_in, .wr_strobe_in, .rd_strobe_in,
        .enhanced_mode_in, .fdc_config_f1_in, .fdc_config_f2_in, .output_control_reg_in,
        .ctrl_resetn_in, .config_control_reg_wr_in, .config_control_reg_rate_in,
        .drive_rate_type_in, .drive_kind_in, .fifo_status_access_in, .start_track_wr_in,
        .start_track_in, .cur_track_in, .rd_data_out, .rd_data_oe_out, .rate_code_out,
        .data_rate_out, .precomp_hsteps_out, .precomp_en_out, .density_level_out,
        .density_out_pins_out, .low_power_out, .ctrl_reset_out
    );
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask
    // one-cycle strobes, released at the edge that samples them
    // every rate write in this bench keeps bit 5 at zero
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_strobe_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge clk_in);
        wr_strobe_in <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a);
        @(posedge clk_in);
        rd_strobe_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_strobe_in <= 1'b0;
        @(negedge clk_in); // read data stand in this cycle only
    endtask
    task automatic cfg_rate(input logic [1:0] r);
        @(posedge clk_in);
        config_control_reg_wr_in <= 1'b1;
        config_control_reg_rate_in <= r;
        @(posedge clk_in);
        config_control_reg_wr_in <= 1'b0;
    endtask
    // rate-derived outputs trail the write by two edges
    task automatic lag2;
        @(posedge clk_in);
        @(negedge clk_in);
    endtask
    task automatic t_tape;
        wr(`FDCRP_TAPE_OFS, 8'hfd);
        rd(`FDCRP_TAPE_OFS);
        chk(rd_data_oe_out, 8'h03, "normal enable");
        chk(rd_data_out & 8'h03, 8'h01, "tape bits");
        rd(`FDCRP_RATE_OFS);
        chk(rd_data_oe_out, 8'h00, "rate reg read");
        @(posedge clk_in);
        enhanced_mode_in <= 1'b1;
        fdc_config_f1_in <= 8'ha5;
        fdc_config_f2_in <= 8'h1b;
        for (int s = 0; s < 4; s++) begin
            @(posedge clk_in);
            output_control_reg_in <= 2'(s);
            rd(`FDCRP_TAPE_OFS);
            chk(rd_data_oe_out, 8'hff, "enh enable");
            chk(rd_data_out & 8'hcf, 8'h49, "media and boot");
            chk((rd_data_out >> 4) & 8'h03, 8'((8'h1b >> (2 * s)) & 8'h03),
                "drive type");
        end
        $display("t_tape done");
    endtask
    task automatic t_rate;
        logic [2:0] r;
        logic       dn;
        for (int t = 0; t < 3; t++) for (int c = 0; c < 4; c++) begin
            @(posedge clk_in);
            drive_rate_type_in <= 2'(t);
            wr(`FDCRP_RATE_OFS, 8'(c));
            lag2;
            r = (c == 3) ? 3'h3 : (c == 0) ? 3'h2 : (c == 2) ? 3'h0 :
                (t == 1) ? 3'h2 : (t == 2) ? 3'h4 : 3'h1;
            dn = (c == 3 || c == 0);
            chk(data_rate_out, r, "rate");
            chk(density_level_out, dn, "density");
            chk(precomp_hsteps_out, (r == 3'h4) ? 8'h01 : (r == 3'h3) ? 8'h02 : 8'h06,
                "default delay");
            for (int k = 0; k < 4; k++) begin
                @(posedge clk_in);
                drive_kind_in <= 2'(k);
                lag2;
                chk(density_out_pins_out, (k == 0) ? {c[0], dn} : (k == 2) ? {c[0], c[1]} :
                    (k == 1) ? {c[0], ~dn} : {c[1], c[0]}, "pins");
            end
        end
        $display("t_rate done");
    endtask
    task automatic t_precomp; // drive rate type is still 10 here
        for (int c = 1; c < 8; c++) begin
            wr(`FDCRP_RATE_OFS, 8'(c << 2) | 8'h03);
            lag2;
            chk(precomp_hsteps_out, (c == 7) ? 8'h00 : 8'(2 * c), "delay 1M");
            wr(`FDCRP_RATE_OFS, 8'(c << 2) | 8'h01);
            lag2;
            chk(precomp_hsteps_out, (c == 7) ? 8'h00 : 8'(c), "delay 2M");
        end
        $display("t_precomp done");
    endtask
    task automatic t_ccr;
        wr(`FDCRP_RATE_OFS, 8'h00);
        cfg_rate(2'h3);
        @(negedge clk_in);
        chk(rate_code_out, 8'h03, "config latest");
        fork
            wr(`FDCRP_RATE_OFS, 8'h02);
            cfg_rate(2'h0);
        join
        @(negedge clk_in);
        chk(rate_code_out, 8'h02, "same cycle write");
        $display("t_ccr done");
    endtask
    task automatic t_power;
        int n;
        wr(`FDCRP_RATE_OFS, 8'h42);
        @(negedge clk_in);
        chk(low_power_out, 8'h01, "low power on");
        @(posedge clk_in);
        fifo_status_access_in <= 1'b1;
        @(posedge clk_in);
        fifo_status_access_in <= 1'b0;
        @(negedge clk_in);
        chk(low_power_out, 8'h00, "access wakes");
        wr(`FDCRP_RATE_OFS, 8'h42);
        @(posedge clk_in);
        ctrl_resetn_in <= 1'b0;
        @(posedge clk_in);
        ctrl_resetn_in <= 1'b1;
        @(negedge clk_in);
        chk(low_power_out, 8'h00, "soft reset wakes");
        chk(ctrl_reset_out, 8'h01, "control reset");
        // a new rate code with the reset bit: the soft reset must not touch it
        wr(`FDCRP_RATE_OFS, 8'hc3);
        n = 0;
        repeat (30) begin
            @(negedge clk_in);
            n += ctrl_reset_out;
        end
        chk(8'(n), 8'h14, "self clearing");
        chk(low_power_out, 8'h00, "reset ends low power");
        chk(rate_code_out, 8'h03, "rate kept");
        $display("t_power done");
    endtask
    task automatic t_track_hw;
        @(posedge clk_in);
        start_track_wr_in <= 1'b1;
        start_track_in <= 8'h05;
        cur_track_in <= 8'h04;
        @(posedge clk_in);
        start_track_wr_in <= 1'b0;
        lag2;
        chk(precomp_en_out, 8'h00, "below start");
        wr(`FDCRP_RATE_OFS, 8'h1f);
        @(posedge clk_in);
        resetn_in <= 1'b0;
        @(posedge clk_in);
        resetn_in <= 1'b1;
        lag2;
        chk(rate_code_out, 8'h02, "hard reset code");
        chk(precomp_en_out, 8'h01, "start back at 0");
        rd(`FDCRP_TAPE_OFS);
        chk(rd_data_out & 8'hc0, 8'h40, "media kept");
        $display("t_track_hw done");
    endtask
    task automatic end_sim;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge clk_in);
        resetn_in <= 1'b1;
        lag2;
        chk(rate_code_out, 8'h02, "reset code");
        chk(precomp_hsteps_out, 8'h06, "reset delay");
        chk(precomp_en_out, 8'h01, "track zero");
        t_tape;
        t_rate;
        t_precomp;
        t_ccr;
        t_power;
        t_track_hw;
        end_sim;
    end
    // hang guard: counts as a mismatch
    initial begin
        #100000;
        fails++;
        end_sim;
    end
endmodule // fdcrp_top_tb_top
`default_nettype wire
